//--- hw/fault_monitor_pkg.sv
// Constants shared by the disc drive fault monitor
`default_nettype none
package fault_monitor_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned SEEK_TMO_MS = 90;
  localparam int unsigned LONG_TMO_MS = 1250;
  localparam int unsigned SEEK_TMO_CYC = SEEK_TMO_MS * (CLK_HZ / 1000);
  localparam int unsigned LONG_TMO_CYC = LONG_TMO_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W = 24;
  localparam int unsigned NUM_TMR = 4;
  localparam int unsigned NUM_IL = 5;
  localparam int unsigned NUM_HEADS = 5;
  // Timer slots
  localparam int unsigned TMR_SEEK = 0;
  localparam int unsigned TMR_HOME = 1;
  localparam int unsigned TMR_WDRAW = 2;
  localparam int unsigned TMR_RESTORE = 3;
  // AXI4-Lite register map
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IND = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Status bit positions
  localparam int unsigned ST_READY = 0;
  localparam int unsigned ST_FAULT = 1;
  localparam int unsigned ST_DOOR = 2;
  localparam int unsigned ST_TMO = 3;
endpackage
`default_nettype wire

//--- hw/disc_drive_fault_monitor.sv
// Disc drive fault monitor: ready latch, door release, timeouts, faults
// ============================================================
`default_nettype none
module disc_drive_fault_monitor (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_RUN_STOP,
  input wire logic I_CARRIAGE_RETRACTED,
  input wire logic I_SPINDLE_STOPPED,
  input wire logic I_SERVO_GAIN_VALID,
  input wire logic I_SERVO_BALANCED,
  input wire logic I_DOOR_LOCKED,
  input wire logic I_PACK_IN_PLACE,
  input wire logic I_SPINDLE_AT_SPEED,
  input wire logic I_ACCESS_READY,
  input wire logic I_AT_CYL_ZERO,
  input wire logic I_SEEK_REQUEST,
  input wire logic I_SEEK_TO_ZERO,
  input wire logic I_WITHDRAW_HEADS_CMD,
  input wire logic I_RESTORE_HOME,
  input wire logic [4:0] I_INTERLOCK,
  input wire logic I_WRITE,
  input wire logic I_READ,
  input wire logic I_WRITE_DATA,
  input wire logic [4:0] I_HEAD_SEL,
  input wire logic I_DC_WRITE_CURRENT,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [3:0] I_AWADDR,
  input wire logic I_WVALID,
  output logic O_WREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  output logic O_BVALID,
  input wire logic I_BREADY,
  output logic [1:0] O_BRESP,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  input wire logic [3:0] I_ARADDR,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_DOOR_RELEASE,
  output logic O_DRIVE_READY,
  output logic O_DRIVE_FAULT,
  output logic O_SERVO_LOSS_IND,
  output logic O_CARRIAGE_FAULT_IND,
  output logic O_TIMEOUT_IND,
  output logic O_INTERLOCK_IND,
  output logic O_WRITE_NO_DATA_IND,
  output logic O_MULTI_HEAD_IND,
  output logic O_WRITE_OFF_CYL_IND,
  output logic O_READ_WRITE_IND
);
  localparam int unsigned NIN = 17 + fault_monitor_pkg::NUM_IL
    + fault_monitor_pkg::NUM_HEADS;
  localparam int unsigned NH = fault_monitor_pkg::NUM_HEADS;
  localparam int unsigned NT = fault_monitor_pkg::NUM_TMR;
  localparam int unsigned CW = fault_monitor_pkg::CNT_W;

  // ============================================================
  // Input synchronisers
  logic [NIN-1:0] raw;
  logic [NIN-1:0] meta_r;
  logic [NIN-1:0] sync_r;
  assign raw = {I_RUN_STOP, I_CARRIAGE_RETRACTED, I_SPINDLE_STOPPED,
    I_SERVO_GAIN_VALID, I_SERVO_BALANCED, I_DOOR_LOCKED, I_PACK_IN_PLACE,
    I_SPINDLE_AT_SPEED, I_ACCESS_READY, I_AT_CYL_ZERO, I_SEEK_REQUEST,
    I_SEEK_TO_ZERO, I_WITHDRAW_HEADS_CMD, I_RESTORE_HOME, I_WRITE, I_READ,
    I_WRITE_DATA, I_INTERLOCK, I_HEAD_SEL};

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= raw;
      sync_r <= meta_r;
    end
  end

  logic run_sel, carriage_retracted, spindle_stopped, servo_gain_valid;
  logic servo_balanced, door_locked, pack_in_place, spindle_at_speed;
  logic access_ready, at_cyl_zero, seek_request, seek_to_zero;
  logic withdraw_heads_cmd, restore_home, write_mode, read_mode;
  logic write_data;
  logic [fault_monitor_pkg::NUM_IL-1:0] interlock;
  logic [NH-1:0] head_sel;
  assign {run_sel, carriage_retracted, spindle_stopped, servo_gain_valid,
    servo_balanced, door_locked, pack_in_place, spindle_at_speed,
    access_ready, at_cyl_zero, seek_request, seek_to_zero,
    withdraw_heads_cmd, restore_home, write_mode, read_mode, write_data,
    interlock, head_sel} = sync_r;

  // DC current is sensed separately through its own two flops, with the same two-cycle delay as the other inputs
  logic dc_meta_r, dc_write_current;
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      dc_meta_r <= 1'b0;
      dc_write_current <= 1'b0;
    end else begin
      dc_meta_r <= I_DC_WRITE_CURRENT;
      dc_write_current <= dc_meta_r;
    end
  end

  function automatic logic multi_sel(input logic [NH-1:0] v);
    int n;
    n = 0;
    for (int k = 0; k < NH; k++) n += int'(v[k]);
    return n > 1;
  endfunction

  // ============================================================
  // Software control: force stop and clear latched timeouts
  logic sw_stop_r;
  logic tmo_clr;
  logic stop_sel;
  assign stop_sel = ~run_sel | sw_stop_r;

  // ============================================================
  // Fault decode
  logic heads_multi_selected, write_without_data, write_off_cylinder;
  logic read_with_write, dc_stray, interlock_fault, carriage_sensor_fault;
  logic servo_signal_loss_fault, timeout_fault, any_fault;
  logic drive_ready_latch;
  logic [NT-1:0] tmo_r;

  assign heads_multi_selected = multi_sel(head_sel);
  assign dc_stray = dc_write_current & ~write_mode;
  assign write_without_data = write_mode & ~write_data;
  assign write_off_cylinder = write_mode & ~access_ready;
  assign read_with_write = read_mode & write_mode;
  assign interlock_fault = |interlock;
  assign carriage_sensor_fault =
    carriage_retracted & drive_ready_latch;
  // Loss of gain only counts once the drive has come ready
  assign servo_signal_loss_fault =
    ~servo_gain_valid & drive_ready_latch;
  assign timeout_fault = |tmo_r;
  assign any_fault = servo_signal_loss_fault | carriage_sensor_fault
    | timeout_fault | interlock_fault | write_without_data
    | write_off_cylinder | read_with_write | heads_multi_selected
    | dc_stray;

  // ============================================================
  // Drive ready latch; clear beats set so the latch cannot set while any fault is present
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      drive_ready_latch <= 1'b0;
    end else if (any_fault | ~(door_locked & pack_in_place)
                 | ~spindle_at_speed | stop_sel) begin
      drive_ready_latch <= 1'b0;
    end else if (servo_gain_valid & servo_balanced) begin
      drive_ready_latch <= 1'b1;
    end
  end

  // ============================================================
  // Timeout counters, one per positioning command
  logic [NT-1:0] trig;
  logic [NT-1:0] done;
  logic [NT-1:0] trig_d_r;
  logic [NT-1:0] run_r;
  logic [CW-1:0] cnt_r [NT];
  logic [CW-1:0] limit [NT];
  assign trig = {restore_home, withdraw_heads_cmd, seek_to_zero,
    seek_request};
  // Seek done on access ready; home moves done on cylinder zero
  assign done = {at_cyl_zero & access_ready, carriage_retracted,
    at_cyl_zero & access_ready, access_ready};
  assign limit[fault_monitor_pkg::TMR_SEEK] =
    CW'(fault_monitor_pkg::SEEK_TMO_CYC);
  assign limit[fault_monitor_pkg::TMR_HOME] =
    CW'(fault_monitor_pkg::LONG_TMO_CYC);
  assign limit[fault_monitor_pkg::TMR_WDRAW] =
    CW'(fault_monitor_pkg::LONG_TMO_CYC);
  assign limit[fault_monitor_pkg::TMR_RESTORE] =
    CW'(fault_monitor_pkg::LONG_TMO_CYC);

  always_ff @(posedge I_CLK) begin
    if (I_RST) trig_d_r <= '0;
    else trig_d_r <= trig;
  end

  for (genvar t = 0; t < NT; t++) begin : g_tmr
    always_ff @(posedge I_CLK) begin
      if (I_RST) begin
        run_r[t] <= 1'b0;
        cnt_r[t] <= '0;
        tmo_r[t] <= 1'b0;
      end else begin
        if (trig[t] & ~trig_d_r[t]) begin
          run_r[t] <= 1'b1;
          cnt_r[t] <= '0;
        end else if (run_r[t] & done[t]) begin
          run_r[t] <= 1'b0;
        end else if (run_r[t]) begin
          cnt_r[t] <= cnt_r[t] + CW'(1);
          if (cnt_r[t] + CW'(1) >= limit[t]) begin
            run_r[t] <= 1'b0;
          end
        end
        // Expiry sets even in a clearing cycle
        if (run_r[t] & ~done[t] & ~(trig[t] & ~trig_d_r[t])
            & (cnt_r[t] + CW'(1) >= limit[t])) begin
          tmo_r[t] <= 1'b1;
        end else if (tmo_clr) begin
          tmo_r[t] <= 1'b0;
        end
      end
    end
  end

  // ============================================================
  // Outputs, all registered
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_DOOR_RELEASE <= 1'b0;
      O_DRIVE_READY <= 1'b0;
      O_DRIVE_FAULT <= 1'b0;
      O_SERVO_LOSS_IND <= 1'b0;
      O_CARRIAGE_FAULT_IND <= 1'b0;
      O_TIMEOUT_IND <= 1'b0;
      O_INTERLOCK_IND <= 1'b0;
      O_WRITE_NO_DATA_IND <= 1'b0;
      O_MULTI_HEAD_IND <= 1'b0;
      O_WRITE_OFF_CYL_IND <= 1'b0;
      O_READ_WRITE_IND <= 1'b0;
    end else begin
      O_DOOR_RELEASE <=
        stop_sel & carriage_retracted & spindle_stopped;
      O_DRIVE_READY <= drive_ready_latch;
      O_DRIVE_FAULT <= any_fault;
      O_SERVO_LOSS_IND <= servo_signal_loss_fault;
      O_CARRIAGE_FAULT_IND <= carriage_sensor_fault;
      O_TIMEOUT_IND <= timeout_fault;
      O_INTERLOCK_IND <= interlock_fault;
      O_WRITE_NO_DATA_IND <=
        write_without_data | dc_stray;
      O_MULTI_HEAD_IND <= heads_multi_selected | dc_stray;
      O_WRITE_OFF_CYL_IND <= write_off_cylinder;
      O_READ_WRITE_IND <= read_with_write;
    end
  end

  // ============================================================
  // AXI4-Lite slave: address and data taken in either order
  logic aw_got_r, w_got_r;
  logic [3:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_fire;
  assign wr_fire = aw_got_r & w_got_r & ~O_BVALID;
  assign tmo_clr = wr_fire & (awaddr_r == fault_monitor_pkg::ADDR_CTRL)
    & wstrb_r[0] & wdata_r[1];

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_AWREADY <= 1'b0;
      O_WREADY <= 1'b0;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      O_BVALID <= 1'b0;
      O_BRESP <= fault_monitor_pkg::RESP_OKAY;
      sw_stop_r <= 1'b0;
    end else begin
      O_AWREADY <= ~aw_got_r & ~O_AWREADY & I_AWVALID;
      O_WREADY <= ~w_got_r & ~O_WREADY & I_WVALID;
      if (O_AWREADY & I_AWVALID) begin
        aw_got_r <= 1'b1;
        awaddr_r <= I_AWADDR;
      end
      if (O_WREADY & I_WVALID) begin
        w_got_r <= 1'b1;
        wdata_r <= I_WDATA;
        wstrb_r <= I_WSTRB;
      end
      if (wr_fire) begin
        O_BVALID <= 1'b1;
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        if (awaddr_r == fault_monitor_pkg::ADDR_CTRL) begin
          O_BRESP <= fault_monitor_pkg::RESP_OKAY;
          if (wstrb_r[0]) sw_stop_r <= wdata_r[0];
        end else begin
          O_BRESP <= fault_monitor_pkg::RESP_SLVERR;
        end
      end else if (O_BVALID & I_BREADY) begin
        O_BVALID <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_ARREADY <= 1'b0;
      O_RVALID <= 1'b0;
      O_RDATA <= '0;
      O_RRESP <= fault_monitor_pkg::RESP_OKAY;
    end else begin
      O_ARREADY <= ~O_ARREADY & ~O_RVALID & I_ARVALID;
      if (O_ARREADY & I_ARVALID) begin
        O_RVALID <= 1'b1;
        O_RRESP <= fault_monitor_pkg::RESP_OKAY;
        unique case (I_ARADDR)
          fault_monitor_pkg::ADDR_CTRL: O_RDATA <= {31'h0, sw_stop_r};
          fault_monitor_pkg::ADDR_STATUS: O_RDATA <= {28'h0, timeout_fault,
            O_DOOR_RELEASE, O_DRIVE_FAULT, drive_ready_latch};
          fault_monitor_pkg::ADDR_IND: O_RDATA <= {21'h0, tmo_r,
            O_SERVO_LOSS_IND, O_CARRIAGE_FAULT_IND, O_INTERLOCK_IND,
            O_WRITE_NO_DATA_IND, O_MULTI_HEAD_IND, O_WRITE_OFF_CYL_IND,
            O_READ_WRITE_IND};
          default: begin
            O_RDATA <= '0;
            O_RRESP <= fault_monitor_pkg::RESP_SLVERR;
          end
        endcase
      end else if (O_RVALID & I_RREADY) begin
        O_RVALID <= 1'b0;
      end
    end
  end

  // ============================================================
  // Checks
  sequence s_ready_cond;
    servo_gain_valid & servo_balanced & ~any_fault & door_locked
      & pack_in_place & spindle_at_speed & ~stop_sel;
  endsequence

  AST_DOOR: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    O_DOOR_RELEASE |-> $past(stop_sel & carriage_retracted
      & spindle_stopped)) else $error("door release without conditions");
  AST_READY_SET: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    s_ready_cond |=> drive_ready_latch) else $error("ready not set");
  AST_READY_CLR: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    (any_fault | stop_sel) |=> ~drive_ready_latch)
    else $error("ready not cleared");
  AST_FAULT_OR: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    (interlock_fault | timeout_fault | read_with_write) |=> O_DRIVE_FAULT)
    else $error("summary fault missing");
  AST_SERVO: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    O_SERVO_LOSS_IND |-> $past(drive_ready_latch))
    else $error("servo indicator without ready");
  AST_CARR: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    (carriage_retracted & drive_ready_latch) |=> O_CARRIAGE_FAULT_IND)
    else $error("carriage fault missed");
  AST_DCW: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    dc_stray |=> O_MULTI_HEAD_IND & O_WRITE_NO_DATA_IND)
    else $error("stray dc write not flagged");
  AST_TMO_LATCH: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    (timeout_fault & ~tmo_clr) |=> timeout_fault)
    else $error("timeout fault dropped");
  AST_SEEK_TMO: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    (run_r[fault_monitor_pkg::TMR_SEEK] & ~done[fault_monitor_pkg::TMR_SEEK]
      & (cnt_r[fault_monitor_pkg::TMR_SEEK]
        == limit[fault_monitor_pkg::TMR_SEEK] - CW'(1))
      & ~(trig[fault_monitor_pkg::TMR_SEEK]
        & ~trig_d_r[fault_monitor_pkg::TMR_SEEK]))
    |=> tmo_r[fault_monitor_pkg::TMR_SEEK])
    else $error("seek timeout missed");
endmodule
`default_nettype wire

//--- verif/disc_ctrl_model.sv
// Behavioural disc controller driving seek and read/write lines
`default_nettype none
module disc_ctrl_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_op,
  input wire logic i_access_ready,
  output logic o_seek,
  output logic o_read,
  output logic o_write,
  output logic o_write_data,
  output logic [4:0] o_heads
);
  timeunit 1ns;
  timeprecision 1ps;
  // ============================================================
  // Command decode
  // Ops: 0 idle, 1 write, 2 write without data, 3 read with write,
  // 4 read on two heads, 5 seek; ops 2 to 4 are faults on purpose
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_seek <= 1'b0;
      o_read <= 1'b0;
      o_write <= 1'b0;
      o_write_data <= 1'b0;
      o_heads <= 5'h00;
    end else begin
      // Seek only from settled heads; no cylinder address exists here
      o_seek <= (i_op == 3'h5) && i_access_ready;
      o_write <= (i_op >= 3'h1) && (i_op <= 3'h3);
      o_write_data <= (i_op == 3'h1) || (i_op == 3'h3);
      o_read <= (i_op == 3'h3) || (i_op == 3'h4);
      o_heads <= (i_op == 3'h4) ? 5'h03 : 5'h01;
    end
  end
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench for the disc drive fault monitor
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ============================================================
  // Signals
  logic clk, rst, run, carr, stopd, gain, bal, door, pack, speed, acc;
  logic zero, home, wdraw, rest, dcc, awvalid, wvalid, bready;
  logic arvalid, rready;
  logic [4:0] il;
  logic [2:0] op;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, v;
  logic [1:0] r;
  wire seek, rd, wr, wd, awready, wready, bvalid, arready, rvalid;
  wire [4:0] hs;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [10:0] outs;
  int n_fail, check_count;
  logic [2:0] f_op [5] = '{3'h2, 3'h4, 3'h0, 3'h1, 3'h3};
  logic f_acc [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
  logic f_dc [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
  logic [10:0] f_exp [5] = '{11'h084, 11'h104, 11'h184, 11'h204, 11'h404};

  disc_ctrl_model u_disc_ctrl_model (
    .i_clk(clk), .i_rst(rst), .i_op(op), .i_access_ready(acc),
    .o_seek(seek), .o_read(rd), .o_write(wr), .o_write_data(wd),
    .o_heads(hs)
  );
  disc_drive_fault_monitor u_disc_drive_fault_monitor (
    .I_CLK(clk), .I_RST(rst), .I_RUN_STOP(run),
    .I_CARRIAGE_RETRACTED(carr), .I_SPINDLE_STOPPED(stopd),
    .I_SERVO_GAIN_VALID(gain), .I_SERVO_BALANCED(bal),
    .I_DOOR_LOCKED(door), .I_PACK_IN_PLACE(pack),
    .I_SPINDLE_AT_SPEED(speed), .I_ACCESS_READY(acc),
    .I_AT_CYL_ZERO(zero), .I_SEEK_REQUEST(seek), .I_SEEK_TO_ZERO(home),
    .I_WITHDRAW_HEADS_CMD(wdraw), .I_RESTORE_HOME(rest),
    .I_INTERLOCK(il), .I_WRITE(wr), .I_READ(rd), .I_WRITE_DATA(wd),
    .I_HEAD_SEL(hs), .I_DC_WRITE_CURRENT(dcc),
    .I_AWVALID(awvalid), .O_AWREADY(awready), .I_AWADDR(awaddr),
    .I_WVALID(wvalid), .O_WREADY(wready), .I_WDATA(wdata),
    .I_WSTRB(wstrb), .O_BVALID(bvalid), .I_BREADY(bready),
    .O_BRESP(bresp), .I_ARVALID(arvalid), .O_ARREADY(arready),
    .I_ARADDR(araddr), .O_RVALID(rvalid), .I_RREADY(rready),
    .O_RDATA(rdata), .O_RRESP(rresp),
    .O_DOOR_RELEASE(outs[0]), .O_DRIVE_READY(outs[1]),
    .O_DRIVE_FAULT(outs[2]), .O_SERVO_LOSS_IND(outs[3]),
    .O_TIMEOUT_IND(outs[4]), .O_CARRIAGE_FAULT_IND(outs[5]),
    .O_INTERLOCK_IND(outs[6]), .O_WRITE_NO_DATA_IND(outs[7]),
    .O_MULTI_HEAD_IND(outs[8]), .O_WRITE_OFF_CYL_IND(outs[9]),
    .O_READ_WRITE_IND(outs[10])
  );

  // ============================================================
  // Report and compare
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t word got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_out(input logic [10:0] exp);
    check_count++;
    if (outs !== exp) begin
      n_fail++;
      $display("[ERR] %0t outs got %h exp %h", $time, outs, exp);
    end
  endtask
  task automatic hang();
    n_fail++;
    $display("[ERR] %0t wait got %h exp %h", $time, 1'b0, 1'b1);
    wrap_up();
  endtask
  // Indicators that pulse for a cycle are polled, not sampled once
  task automatic wait_bit(input int idx);
    int i;
    check_count++;
    for (i = 0; i < 8; i++) begin
      @(posedge clk);
      if (outs[idx] === 1'b1) break;
    end
    if (i == 8) begin
      n_fail++;
      $display("[ERR] %0t bit %0d got %h exp %h", $time, idx, 1'b0, 1'b1);
    end
  endtask
  // Pins reach the indicator outputs after three edges, O_DRIVE_READY after four
  task automatic settle();
    repeat (5) @(posedge clk);
  endtask

  // ============================================================
  // Register bus master
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        output logic [1:0] rs);
    int i;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    rs = bresp;
    if (i == 40) hang();
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                        output logic [1:0] rs);
    int i;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    d = rdata;
    rs = rresp;
    if (i == 40) hang();
  endtask

  // ============================================================
  // Stimulus
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    rst <= 1'b1; run <= 1'b1; carr <= 1'b0; stopd <= 1'b0; gain <= 1'b0;
    bal <= 1'b0; door <= 1'b1; pack <= 1'b1; speed <= 1'b1; acc <= 1'b1;
    zero <= 1'b0; home <= 1'b0; wdraw <= 1'b0; rest <= 1'b0; dcc <= 1'b0;
    il <= 5'h00; op <= 3'h0; awvalid <= 1'b0; wvalid <= 1'b0;
    bready <= 1'b0; arvalid <= 1'b0; rready <= 1'b0; awaddr <= 4'h0;
    araddr <= 4'h0; wstrb <= 4'hF; wdata <= 32'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    settle();
    chk_out(11'h000);
    for (int i = 0; i < 5; i++) begin
      il <= 5'h01 << i;
      settle();
      chk_out(11'h044);
      il <= 5'h00;
      settle();
    end
    $display("test interlock done");
    for (int i = 0; i < 5; i++) begin
      op <= f_op[i];
      acc <= f_acc[i];
      dcc <= f_dc[i];
      settle();
      chk_out(f_exp[i]);
      axi_rd(fault_monitor_pkg::ADDR_IND, v, r);
      chk_word(v, {27'h0, f_exp[i][6], f_exp[i][7], f_exp[i][8],
                   f_exp[i][9], f_exp[i][10]});
      op <= 3'h0;
      acc <= 1'b1;
      dcc <= 1'b0;
      settle();
    end
    $display("test write faults done");
    op <= 3'h5;
    repeat (2) @(posedge clk);
    op <= 3'h0;
    acc <= 1'b0;
    repeat (5) @(posedge clk);
    acc <= 1'b1;
    zero <= 1'b1; carr <= 1'b1; home <= 1'b1; wdraw <= 1'b1; rest <= 1'b1;
    settle();
    zero <= 1'b0; carr <= 1'b0; home <= 1'b0; wdraw <= 1'b0; rest <= 1'b0;
    repeat (20) @(posedge clk);
    chk_out(11'h000);
    axi_wr(fault_monitor_pkg::ADDR_CTRL, 32'h2, r);
    axi_rd(fault_monitor_pkg::ADDR_CTRL, v, r);
    chk_word(v, 32'h0);
    $display("test timers done");
    gain <= 1'b1;
    bal <= 1'b1;
    settle();
    chk_out(11'h002);
    axi_rd(fault_monitor_pkg::ADDR_STATUS, v, r);
    chk_word(v, 32'h1);
    bal <= 1'b0;
    settle();
    chk_out(11'h002);
    bal <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      case (i)
        0: run <= 1'b0;
        1: door <= 1'b0;
        2: pack <= 1'b0;
        default: speed <= 1'b0;
      endcase
      settle();
      chk_out(11'h000);
      run <= 1'b1; door <= 1'b1; pack <= 1'b1; speed <= 1'b1;
      settle();
      chk_out(11'h002);
    end
    axi_wr(fault_monitor_pkg::ADDR_CTRL, 32'h1, r);
    settle();
    chk_out(11'h000);
    axi_rd(fault_monitor_pkg::ADDR_CTRL, v, r);
    chk_word(v, 32'h1);
    axi_wr(fault_monitor_pkg::ADDR_CTRL, 32'h0, r);
    axi_wr(4'hC, 32'hFFFF_FFFF, r);
    chk_word({30'h0, r}, {30'h0, fault_monitor_pkg::RESP_SLVERR});
    axi_rd(4'hC, v, r);
    chk_word({30'h0, r}, {30'h0, fault_monitor_pkg::RESP_SLVERR});
    chk_word(v, 32'h0);
    settle();
    chk_out(11'h002);
    $display("test ready latch done");
    gain <= 1'b0;
    wait_bit(3);
    settle();
    chk_out(11'h000);
    gain <= 1'b1;
    settle();
    carr <= 1'b1;
    wait_bit(5);
    settle();
    chk_out(11'h000);
    $display("test servo and carriage done");
    gain <= 1'b0;
    run <= 1'b0;
    stopd <= 1'b1;
    settle();
    chk_out(11'h001);
    stopd <= 1'b0;
    settle();
    chk_out(11'h000);
    $display("test door release done");
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge clk);
    hang();
  end
endmodule
`default_nettype wire
